// >>> design/tmf_params.svh
// Constants for the test-mode contact forcing block.
// Assumes a 200 MHz clk; included by the flasher and controller design files.
`ifndef TMF_PARAMS_SVH
`define TMF_PARAMS_SVH
`define TMF_NUM_IN 8
`define TMF_NUM_OUT 8
`define TMF_CLK_MHZ 200
`define TMF_FLASH_HALF_MS 250
`define TMF_FLASH_HALF_CYC (`TMF_FLASH_HALF_MS * 1000 * `TMF_CLK_MHZ)
`define TMF_CNT_W 26
`define TMF_IN_FORCE_W 2
`define TMF_OUT_FORCE_W 2
`endif

// >>> design/tmf_pkg.sv
// Types for the test-mode contact forcing block.
// Assumes tmf_params.svh constants are available.
package tmf_pkg;
  typedef enum logic [1:0] {
    TMF_IN_DISABLED,
    TMF_IN_OPEN,
    TMF_IN_CLOSED
  } tmf_in_force_t;
  typedef enum logic [1:0] {
    TMF_OUT_DISABLED,
    TMF_OUT_ENERGIZE,
    TMF_OUT_DEENERGIZE,
    TMF_OUT_FREEZE
  } tmf_out_force_t;
  typedef enum logic [1:0] {
    TMF_IDLE,
    TMF_ARMED,
    TMF_ACTIVE
  } tmf_state_t;
endpackage

// >>> design/tmf_pin_sync.sv
// Three-flop input synchroniser with agreement filter for one contact pin.
// Assumes an asynchronous level from outside the clk domain.
`timescale 1ns/10ps
`default_nettype none
module tmf_pin_sync (
  input wire logic clk,
  input wire logic nrst,
  input wire logic pin,
  output logic level
);
  logic s1;
  logic s2;
  logic s3;
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      s1 <= 1'b0;
      s2 <= 1'b0;
      s3 <= 1'b0;
    end else begin
      s1 <= pin;
      s2 <= s1;
      s3 <= s2;
    end
  end
  // A change counts only once stages two and three agree
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      level <= 1'b0;
    end else if (s2 == s3) begin
      level <= s3;
    end
  end
endmodule // tmf_pin_sync
`default_nettype wire

// >>> design/tmf_flasher.sv
// Blink generator for the faceplate test indicator.
// Assumes one clk; runs only while enabled, restarts its count from zero each time.
`timescale 1ns/10ps
`default_nettype none
`include "tmf_params.svh"
module tmf_flasher #(
  parameter int unsigned HALF_CYC = `TMF_FLASH_HALF_CYC
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic enable,
  output logic tick
);
  logic [`TMF_CNT_W-1:0] count;
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      count <= '0;
      tick <= 1'b0;
    end else if (!enable) begin
      count <= '0;
      tick <= 1'b0;
    end else if (count == `TMF_CNT_W'(HALF_CYC - 1)) begin
      count <= '0;
      tick <= 1'b1;
    end else begin
      count <= count + `TMF_CNT_W'(1);
      tick <= 1'b0;
    end
  end
endmodule // tmf_flasher
`default_nettype wire

// >>> design/tmf_test_mode.sv
// Test-mode controller: entry, indicator, contact input and output forcing.
// Assumes contact pins are asynchronous; settings and operands are on clk.
// Operation
// - Test mode needs function enabled and trigger high
// - Tied-on trigger starts on enable rising
// - Operand trigger starts when operand goes high
// - Indicator flashes while test mode active
// - Other functions run unchanged in test
// - Separate force selection per input, output
// - Disabled input follows terminal voltage
// - Open input reads zero during test
// - Closed input reads one during test
// - All disabled: inputs report normally
// - Outputs: open, closed, frozen or operational
// - Freeze holds pre-test output position
// - Energize closes, de-energize opens, whole test
`timescale 1ns/10ps
`default_nettype none
`include "tmf_params.svh"
module tmf_test_mode #(
  parameter int unsigned FLASH_HALF_CYC = `TMF_FLASH_HALF_CYC
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic testEnable,
  input wire logic initiateTiedOn,
  input wire logic initiateOperand,
  input wire logic [`TMF_NUM_IN-1:0] contactPin,
  input wire logic [`TMF_NUM_IN*`TMF_IN_FORCE_W-1:0] inForceSel,
  input wire logic [`TMF_NUM_OUT-1:0] outOperand,
  input wire logic [`TMF_NUM_OUT*`TMF_OUT_FORCE_W-1:0] outForceSel,
  output logic [`TMF_NUM_IN-1:0] contactState,
  output logic [`TMF_NUM_OUT-1:0] contactDrive,
  output logic testActive,
  output logic testLed
);
  tmf_pkg::tmf_state_t state;
  tmf_pkg::tmf_state_t next_state;
  logic [`TMF_NUM_IN-1:0] pinLevel;
  logic [`TMF_NUM_OUT-1:0] frozen;
  logic enablePrev;
  logic triggerLevel;
  logic enableRise;
  logic flashTick;

  function automatic logic forceInput(input logic [1:0] sel, input logic raw);
    tmf_pkg::tmf_in_force_t s;
    s = tmf_pkg::tmf_in_force_t'(sel);
    case (s)
      tmf_pkg::TMF_IN_OPEN: forceInput = 1'b0;
      tmf_pkg::TMF_IN_CLOSED: forceInput = 1'b1;
      default: forceInput = raw;
    endcase
  endfunction

  function automatic logic forceOutput(input logic [1:0] sel, input logic op, input logic held);
    tmf_pkg::tmf_out_force_t s;
    s = tmf_pkg::tmf_out_force_t'(sel);
    case (s)
      tmf_pkg::TMF_OUT_ENERGIZE: forceOutput = 1'b1;
      tmf_pkg::TMF_OUT_DEENERGIZE: forceOutput = 1'b0;
      tmf_pkg::TMF_OUT_FREEZE: forceOutput = held;
      default: forceOutput = op;
    endcase
  endfunction

  genvar gi;
  generate
    for (gi = 0; gi < `TMF_NUM_IN; gi++) begin : g_sync
      tmf_pin_sync u_sync (
        .clk(clk),
        .nrst(nrst),
        .pin(contactPin[gi]),
        .level(pinLevel[gi])
      );
    end
  endgenerate

  tmf_flasher #(
    .HALF_CYC(FLASH_HALF_CYC)
  ) u_flash (
    .clk(clk),
    .nrst(nrst),
    .enable(testActive),
    .tick(flashTick)
  );

  // Tied-on trigger is satisfied at once, the operand trigger needs a high level
  assign triggerLevel = initiateTiedOn | initiateOperand;
  assign enableRise = testEnable & ~enablePrev;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      enablePrev <= 1'b0;
    end else begin
      enablePrev <= testEnable;
    end
  end

  // Raising the tied-on trigger while already enabled only arms the block: with the
  // tied-on trigger, entry waits for the enable edge itself.
  always_comb begin
    next_state = state;
    case (state)
      tmf_pkg::TMF_IDLE: begin
        if (testEnable && (initiateOperand || (enableRise && initiateTiedOn))) begin
          next_state = tmf_pkg::TMF_ACTIVE;
        end else if (testEnable && !enableRise) begin
          next_state = tmf_pkg::TMF_ARMED;
        end
      end
      tmf_pkg::TMF_ARMED: begin
        if (!testEnable) begin
          next_state = tmf_pkg::TMF_IDLE;
        end else if (initiateOperand) begin
          next_state = tmf_pkg::TMF_ACTIVE;
        end
      end
      tmf_pkg::TMF_ACTIVE: begin
        if (!testEnable || !triggerLevel) begin
          next_state = testEnable ? tmf_pkg::TMF_ARMED : tmf_pkg::TMF_IDLE;
        end
      end
      default: next_state = tmf_pkg::TMF_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state <= tmf_pkg::TMF_IDLE;
    end else begin
      state <= next_state;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      testActive <= 1'b0;
    end else begin
      testActive <= (next_state == tmf_pkg::TMF_ACTIVE);
    end
  end

  // Indicator is lit on entry and toggles each half period
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      testLed <= 1'b0;
    end else if (next_state != tmf_pkg::TMF_ACTIVE) begin
      testLed <= 1'b0;
    end else if (!testActive) begin
      testLed <= 1'b1;
    end else if (flashTick) begin
      testLed <= ~testLed;
    end
  end

  // Snapshot of the normal drive value, held once test mode is entered.
  // Taking the operand rather than the drive avoids a one-cycle step back.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      frozen <= '0;
    end else if (!testActive) begin
      frozen <= outOperand;
    end
  end

  // Per-contact forcing; selections only bite while test mode is active.
  // Only contacts are touched, all other logic passes through untouched.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      contactState <= '0;
    end else begin
      for (int i = 0; i < `TMF_NUM_IN; i++) begin
        if (testActive) begin
          contactState[i] <= forceInput(inForceSel[i*`TMF_IN_FORCE_W +: `TMF_IN_FORCE_W],
                                        pinLevel[i]);
        end else begin
          contactState[i] <= pinLevel[i];
        end
      end
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      contactDrive <= '0;
    end else begin
      for (int i = 0; i < `TMF_NUM_OUT; i++) begin
        if (testActive) begin
          contactDrive[i] <= forceOutput(outForceSel[i*`TMF_OUT_FORCE_W +: `TMF_OUT_FORCE_W],
                                         outOperand[i], frozen[i]);
        end else begin
          contactDrive[i] <= outOperand[i];
        end
      end
    end
  end
endmodule // tmf_test_mode
`default_nettype wire

// >>> testbench/tmf_contact_model.sv
// External contact circuits driving the input terminals.
// Assumes the bench picks the level; pins move off the clock edge.
`timescale 1ns/10ps
`default_nettype none
module tmf_contact_model (
  input wire logic clk,
  input wire logic [7:0] level,
  output logic [7:0] contactPin
);
  initial contactPin = 8'h00;
  // Late change keeps the pins unrelated to the sampling edge
  always @(posedge clk) contactPin <= #1.3 level;
endmodule // tmf_contact_model
`default_nettype wire

// >>> testbench/tmf_test_mode_props.sv
// Checker for entry, exit, indicator and contact forcing.
// Assumes binding to tmf_test_mode with a short flash period.
`timescale 1ns/10ps
`default_nettype none
module tmf_test_mode_props (
  input wire logic clk,
  input wire logic nrst,
  input wire logic testEnable,
  input wire logic initiateTiedOn,
  input wire logic initiateOperand,
  input wire logic [15:0] inForceSel,
  input wire logic [7:0] outOperand,
  input wire logic [15:0] outForceSel,
  input wire logic [7:0] contactState,
  input wire logic [7:0] contactDrive,
  input wire logic testActive,
  input wire logic testLed
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!nrst);
  tied_entry_a: assert property ($rose(testEnable) && initiateTiedOn |=> testActive) else $error("no entry");
  operand_entry_a: assert property (testEnable && initiateOperand |=> testActive) else $error("no entry");
  test_exit_a: assert property (!testEnable || !(initiateTiedOn || initiateOperand) |=> !testActive)
    else $error("no exit");
  led_flash_a: assert property ($rose(testActive) |-> testLed ##[1:5] !testLed) else $error("no flash");
  led_dark_a: assert property (!testActive |-> !testLed) else $error("led lit");
  drive_normal_a: assert property (!$past(testActive) |-> contactDrive == $past(outOperand))
    else $error("drive wrong");
  for (genvar i = 0; i < 8; i++) begin : g_force
    in_open_a: assert property ($past(testActive) && $past(inForceSel[2*i+:2]) == 2'h1 |-> !contactState[i])
      else $error("input not open");
    in_closed_a: assert property ($past(testActive) && $past(inForceSel[2*i+:2]) == 2'h2 |-> contactState[i])
      else $error("input not closed");
    out_energ_a: assert property ($past(testActive) && $past(outForceSel[2*i+:2]) == 2'h1 |-> contactDrive[i])
      else $error("output not closed");
    out_deenerg_a: assert property ($past(testActive) && $past(outForceSel[2*i+:2]) == 2'h2 |-> !contactDrive[i])
      else $error("output not open");
    out_freeze_a: assert property ($past(testActive) && $past(outForceSel[2*i+:2]) == 2'h3 &&
      $past(outForceSel[2*i+:2], 2) == 2'h3 |-> $stable(contactDrive[i])) else $error("output moved");
  end
endmodule // tmf_test_mode_props
`default_nettype wire

// >>> testbench/tmf_test_mode_tb.sv
// Bench for tmf_test_mode: tied and operand entry, input and output forcing.
// Assumes a flash half period of 4 cycles.
`timescale 1ns/10ps
`default_nettype none
module tmf_test_mode_tb;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic testEnable = 1'b0;
  logic initiateTiedOn = 1'b0;
  logic initiateOperand = 1'b0;
  logic [7:0] pinLevel = 8'h00;
  logic [7:0] contactPin;
  logic [15:0] inForceSel = 16'h0000;
  logic [7:0] outOperand = 8'h00;
  logic [15:0] outForceSel = 16'h0000;
  logic [7:0] contactState;
  logic [7:0] contactDrive;
  logic testActive;
  logic testLed;
  int fail_count = 0;
  int num_checks = 0;
  always #2.5 clk = ~clk;
  tmf_contact_model u_model (.clk(clk), .level(pinLevel), .contactPin(contactPin));
  tmf_test_mode #(.FLASH_HALF_CYC(4)) DUT (.clk(clk), .nrst(nrst), .testEnable(testEnable),
    .initiateTiedOn(initiateTiedOn), .initiateOperand(initiateOperand), .contactPin(contactPin),
    .inForceSel(inForceSel), .outOperand(outOperand), .outForceSel(outForceSel),
    .contactState(contactState), .contactDrive(contactDrive), .testActive(testActive), .testLed(testLed));
  task automatic complete_run();
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic wait_act(input logic v);
    int k;
    k = 0;
    while (testActive !== v && k < 20) begin
      cyc(1);
      k++;
    end
    if (testActive !== v) begin
      fail_count++;
      $display("ERROR t=%0t got %h exp %h", $time, testActive, v);
      complete_run();
    end
  endtask
  task automatic reset_check();
    chk(contactState, 8'h00);
    chk(contactDrive, 8'h00);
    chk({6'h00, testActive, testLed}, 8'h00);
  endtask
  task automatic tied_entry();
    int tog;
    logic last;
    tog = 0;
    outOperand = 8'h0A;
    outForceSel = 16'h00C9;
    initiateTiedOn = 1'b1;
    testEnable = 1'b1;
    wait_act(1'b1);
    chk({7'h00, testLed}, 8'h01);
    last = testLed;
    cyc(1);
    outOperand = 8'h04;
    repeat (13) begin
      cyc(1);
      if (testLed !== last) tog++;
      last = testLed;
    end
    chk(8'(tog), 8'h03);
    chk(contactDrive, 8'h0D);
    initiateTiedOn = 1'b0;
    wait_act(1'b0);
    cyc(2);
    chk(contactDrive, 8'h04);
    chk({7'h00, testLed}, 8'h00);
    initiateTiedOn = 1'b1;
    cyc(4);
    chk({7'h00, testActive}, 8'h00);
    testEnable = 1'b0;
    initiateTiedOn = 1'b0;
    outForceSel = 16'h0000;
    cyc(2);
  endtask
  task automatic operand_entry();
    pinLevel = 8'h05;
    inForceSel = 16'h00C9;
    cyc(8);
    chk(contactState, 8'h05);
    testEnable = 1'b1;
    cyc(3);
    chk({7'h00, testActive}, 8'h00);
    initiateOperand = 1'b1;
    wait_act(1'b1);
    cyc(2);
    chk(contactState, 8'h06);
    pinLevel = 8'h0F;
    cyc(8);
    chk(contactState, 8'h0E);
    testEnable = 1'b0;
    wait_act(1'b0);
    cyc(2);
    chk(contactState, 8'h0F);
    initiateOperand = 1'b0;
    inForceSel = 16'h0000;
    cyc(2);
  endtask
  initial begin
    repeat (12) @(negedge clk);
    nrst = 1'b1;
    cyc(2);
    reset_check();
    tied_entry();
    operand_entry();
    complete_run();
  end
endmodule // tmf_test_mode_tb
bind tmf_test_mode tmf_test_mode_props u_props (
  .clk(clk),
  .nrst(nrst),
  .testEnable(testEnable),
  .initiateTiedOn(initiateTiedOn),
  .initiateOperand(initiateOperand),
  .inForceSel(inForceSel),
  .outOperand(outOperand),
  .outForceSel(outForceSel),
  .contactState(contactState),
  .contactDrive(contactDrive),
  .testActive(testActive),
  .testLed(testLed)
);
`default_nettype wire
